// ===== src/carrier_gate.sv
`timescale 1ns/1ps
module carrier_gate (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// carrier under control
	carrier_if.gate cg
);
	logic prev_ff;
	logic act_ff;
	logic nxt_prev;
	logic nxt_act;
	logic fall;

	// R14 handover on fall
	always_comb begin
		nxt_prev = cg.carrier;
		fall = prev_ff & ~cg.carrier;
		if (!cg.sync || fall) begin
			cg.active = cg.want;
		end else begin
			cg.active = act_ff;
		end
		nxt_act = cg.active;
	end

	// edge history and held activity
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_ff <= 1'b0;
			act_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
			act_ff <= nxt_act;
		end
	end
endmodule : carrier_gate

// ===== src/carrier_if.sv
`timescale 1ns/1ps
interface carrier_if;
	logic [3:0] code;
	logic invert;
	logic sync;
	logic want;
	logic carrier;
	logic active;
	modport ctrl (output code, invert, sync, want, input carrier, active);
	modport mux (input code, invert, output carrier);
	modport gate (input sync, want, carrier, output active);
endinterface : carrier_if

// ===== src/carrier_mux.sv
`timescale 1ns/1ps
module carrier_mux (
	// candidate sources, index is the select code
	input wire logic [15:0] sources,
	// control and selected carrier
	carrier_if.mux cm
);
	// pick source, then apply polarity
	always_comb begin
		cm.carrier = sources[cm.code] ^ cm.invert;
	end
endmodule : carrier_mux

// ===== src/data_modulator.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module data_modulator (
	// clock and resets
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic other_reset,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// carrier sources
	input wire logic logic_cell_one_output,
	input wire logic logic_cell_two_output,
	input wire logic logic_cell_three_output,
	input wire logic logic_cell_four_output,
	input wire logic fast_internal_oscillator,
	input wire logic system_osc_clock,
	input wire logic numeric_oscillator_output,
	input wire logic pulse_width_five_output,
	input wire logic pulse_width_six_output,
	input wire logic capture_unit_one_output,
	input wire logic capture_unit_two_output,
	input wire logic reference_clock_signal,
	// other modulation sources
	input wire logic [1:0] comparator_out,
	input wire logic [1:0] serial_data_out,
	input wire logic serial_tx_out,
	// input pins for pin select
	input wire logic [31:0] pin_in,
	// modulated output
	output logic modulated_out
);
	logic [7:0] control_ff;
	logic [7:0] source_ff;
	logic [7:0] high_ff;
	logic [7:0] low_ff;
	logic [7:0] cin1_sel_ff;
	logic [7:0] cin2_sel_ff;
	logic [7:0] min_sel_ff;
	logic [7:0] rdata_ff;
	logic out_ff;
	logic [7:0] nxt_control;
	logic [7:0] nxt_source;
	logic [7:0] nxt_high;
	logic [7:0] nxt_low;
	logic [7:0] nxt_cin1_sel;
	logic [7:0] nxt_cin2_sel;
	logic [7:0] nxt_min_sel;
	logic [7:0] nxt_rdata;
	logic nxt_out;
	logic [15:0] carrier_src;
	logic [15:0] mod_src;
	logic carrier_in1;
	logic carrier_in2;
	logic mod_pin;
	logic mod_sig;
	logic mix;

	carrier_if hi ();
	carrier_if lo ();

	// pin select routing of external inputs
	assign carrier_in1 = pin_in[cin1_sel_ff[dsm_pkg::PIN_W-1:0]];
	assign carrier_in2 = pin_in[cin2_sel_ff[dsm_pkg::PIN_W-1:0]];
	assign mod_pin = pin_in[min_sel_ff[dsm_pkg::PIN_W-1:0]];

	// carrier source table
	always_comb begin
		// R9 ground on zero
		carrier_src[0] = 1'b0;
		// R8 refclk and pins
		carrier_src[1] = carrier_in1;
		carrier_src[2] = carrier_in2;
		carrier_src[3] = reference_clock_signal;
		// R7 capture unit outputs
		carrier_src[4] = capture_unit_one_output;
		carrier_src[5] = capture_unit_two_output;
		// R6 pwm and nco
		carrier_src[6] = pulse_width_five_output;
		carrier_src[7] = pulse_width_six_output;
		carrier_src[8] = numeric_oscillator_output;
		// R5 reserved unconnected
		carrier_src[9] = 1'b0;
		// R4 oscillator sources
		carrier_src[10] = system_osc_clock;
		carrier_src[11] = fast_internal_oscillator;
		// R3 logic cell outputs
		carrier_src[12] = logic_cell_one_output;
		carrier_src[13] = logic_cell_two_output;
		carrier_src[14] = logic_cell_three_output;
		carrier_src[15] = logic_cell_four_output;
	end

	// modulation source table
	always_comb begin
		// R15 software bit source
		mod_src[0] = control_ff[dsm_pkg::SWBIT_BIT];
		mod_src[1] = mod_pin;
		mod_src[2] = capture_unit_one_output;
		mod_src[3] = capture_unit_two_output;
		mod_src[4] = pulse_width_five_output;
		mod_src[5] = pulse_width_six_output;
		mod_src[6] = comparator_out[0];
		mod_src[7] = comparator_out[1];
		mod_src[8] = serial_data_out[0];
		mod_src[9] = serial_data_out[1];
		mod_src[10] = serial_tx_out;
		mod_src[11] = numeric_oscillator_output;
		mod_src[12] = logic_cell_one_output;
		mod_src[13] = logic_cell_two_output;
		mod_src[14] = logic_cell_three_output;
		mod_src[15] = logic_cell_four_output;
		mod_sig = mod_src[dsm_pkg::sel_of(source_ff)];
	end

	// carrier controls from registers
	assign hi.code = dsm_pkg::sel_of(high_ff);
	assign hi.invert = high_ff[dsm_pkg::INV_BIT];
	assign hi.sync = high_ff[dsm_pkg::SYNC_BIT];
	assign hi.want = mod_sig;
	assign lo.code = dsm_pkg::sel_of(low_ff);
	// R1 low polarity
	assign lo.invert = low_ff[dsm_pkg::INV_BIT];
	// R2 low sync enable
	assign lo.sync = low_ff[dsm_pkg::SYNC_BIT];
	assign lo.want = ~mod_sig;

	carrier_mux u_hi_mux (
		.sources(carrier_src),
		.cm(hi.mux)
	);
	carrier_mux u_lo_mux (
		.sources(carrier_src),
		.cm(lo.mux)
	);
	carrier_gate u_hi_gate (
		.mclk(mclk),
		.reset_n(reset_n),
		.cg(hi.gate)
	);
	carrier_gate u_lo_gate (
		.mclk(mclk),
		.reset_n(reset_n),
		.cg(lo.gate)
	);

	// mixing and output polarity
	always_comb begin
		// R12 follow active carrier
		mix = (hi.active & hi.carrier) | (lo.active & lo.carrier);
		// R13 disabled gives idle
		// R16 output polarity
		if (control_ff[dsm_pkg::EN_BIT]) begin
			nxt_out = mix ^ control_ff[dsm_pkg::OPOL_BIT];
		end else begin
			nxt_out = control_ff[dsm_pkg::OPOL_BIT];
		end
	end

	// register writes and read mux
	always_comb begin
		nxt_control = control_ff;
		nxt_source = source_ff;
		nxt_high = high_ff;
		nxt_low = low_ff;
		nxt_cin1_sel = cin1_sel_ff;
		nxt_cin2_sel = cin2_sel_ff;
		nxt_min_sel = min_sel_ff;
		nxt_rdata = 8'h00;
		// R11 keep carriers, disable
		if (other_reset) begin
			nxt_control = dsm_pkg::CONTROL_RST;
		end else if (wr) begin
			case (addr)
				dsm_pkg::OFS_CONTROL: nxt_control = wdata & dsm_pkg::CONTROL_MASK;
				dsm_pkg::OFS_SOURCE: nxt_source = wdata & dsm_pkg::SOURCE_MASK;
				dsm_pkg::OFS_HIGH: nxt_high = wdata & dsm_pkg::CARRIER_MASK;
				// R10 unimplemented bits dropped
				dsm_pkg::OFS_LOW: nxt_low = wdata & dsm_pkg::CARRIER_MASK;
				dsm_pkg::OFS_CIN1_SEL: nxt_cin1_sel = wdata & dsm_pkg::PINSEL_MASK;
				dsm_pkg::OFS_CIN2_SEL: nxt_cin2_sel = wdata & dsm_pkg::PINSEL_MASK;
				dsm_pkg::OFS_MIN_SEL: nxt_min_sel = wdata & dsm_pkg::PINSEL_MASK;
				default: nxt_rdata = 8'h00;
			endcase
		end
		if (rd) begin
			case (addr)
				dsm_pkg::OFS_CONTROL: begin
					nxt_rdata = control_ff;
					nxt_rdata[dsm_pkg::OUT_BIT] = out_ff;
				end
				dsm_pkg::OFS_SOURCE: nxt_rdata = source_ff;
				dsm_pkg::OFS_HIGH: nxt_rdata = high_ff;
				dsm_pkg::OFS_LOW: nxt_rdata = low_ff;
				dsm_pkg::OFS_CIN1_SEL: nxt_rdata = cin1_sel_ff;
				dsm_pkg::OFS_CIN2_SEL: nxt_rdata = cin2_sel_ff;
				dsm_pkg::OFS_MIN_SEL: nxt_rdata = min_sel_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// state registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			control_ff <= dsm_pkg::CONTROL_RST;
			source_ff <= dsm_pkg::CONFIG_RST;
			high_ff <= dsm_pkg::CONFIG_RST;
			low_ff <= dsm_pkg::CONFIG_RST;
			cin1_sel_ff <= dsm_pkg::CONFIG_RST;
			cin2_sel_ff <= dsm_pkg::CONFIG_RST;
			min_sel_ff <= dsm_pkg::CONFIG_RST;
			rdata_ff <= 8'h00;
			out_ff <= 1'b0;
		end else begin
			control_ff <= nxt_control;
			source_ff <= nxt_source;
			high_ff <= nxt_high;
			low_ff <= nxt_low;
			cin1_sel_ff <= nxt_cin1_sel;
			cin2_sel_ff <= nxt_cin2_sel;
			min_sel_ff <= nxt_min_sel;
			rdata_ff <= nxt_rdata;
			out_ff <= nxt_out;
		end
	end

	assign rdata = rdata_ff;
	assign modulated_out = out_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// invert flips low carrier
	low_invert_a: assert property ( // R1
		lo.code == dsm_pkg::SEL_CELL4 |-> lo.carrier == (logic_cell_four_output ^ lo.invert))
		else $error("low carrier polarity wrong");
	// synced low only drops on fall
	low_sync_a: assert property ( // R2
		lo.sync && $fell(lo.active) |-> $fell(lo.carrier))
		else $error("synced low carrier dropped off its falling edge");
	// cell four selected
	cell_select_a: assert property ( // R3
		lo.code == dsm_pkg::SEL_CELL4 && !lo.invert |-> lo.carrier == logic_cell_four_output)
		else $error("cell select wrong");
	// reserved code connects nothing
	reserved_code_a: assert property ( // R5
		lo.code == dsm_pkg::SEL_RSVD |-> lo.carrier == lo.invert)
		else $error("reserved code drives carrier");
	// pin select input one
	pin_input_a: assert property ( // R8
		lo.code == dsm_pkg::SEL_CIN1 |-> lo.carrier == (pin_in[cin1_sel_ff[4:0]] ^ lo.invert))
		else $error("carrier input one routing wrong");
	// ground code
	ground_code_a: assert property ( // R9
		lo.code == dsm_pkg::SEL_VSS |-> lo.carrier == lo.invert)
		else $error("ground code not low");
	// unimplemented bits read zero
	low_readback_a: assert property ( // R10
		wr && addr == dsm_pkg::OFS_LOW && !other_reset ##1 rd && addr == dsm_pkg::OFS_LOW
		|=> rdata == ($past(wdata, 2) & 8'h6f))
		else $error("low carrier readback wrong");
	// carrier fields survive other reset
	keep_fields_a: assert property ( // R11
		other_reset |=> $stable(low_ff) && $stable(high_ff)
		&& !control_ff[dsm_pkg::EN_BIT])
		else $error("other reset disturbed carrier fields");
	// unsynced high tracks data
	mix_follow_a: assert property ( // R12
		control_ff[dsm_pkg::EN_BIT] && !hi.sync && !lo.sync && mod_sig
		|=> modulated_out == $past(hi.carrier ^ control_ff[dsm_pkg::OPOL_BIT]))
		else $error("output does not follow high carrier");
	// disabled idles at polarity
	disabled_idle_a: assert property ( // R13
		!control_ff[dsm_pkg::EN_BIT]
		|=> modulated_out == $past(control_ff[dsm_pkg::OPOL_BIT]))
		else $error("disabled output not idle");
	// unsynced carrier takes over at once
	handover_a: assert property ( // R14
		!lo.sync |-> lo.active == !mod_sig)
		else $error("unsynced low carrier late");
	// software bit modulation
	software_bit_a: assert property ( // R15
		dsm_pkg::sel_of(source_ff) == dsm_pkg::MOD_SW
		|-> mod_sig == control_ff[dsm_pkg::SWBIT_BIT])
		else $error("software bit not used");
	// fast oscillator on code b
	osc_select_a: assert property ( // R4
		lo.code == 4'hb |-> lo.carrier == (fast_internal_oscillator ^ lo.invert))
		else $error("oscillator select wrong");
	// numeric oscillator on code 8
	nco_select_a: assert property ( // R6
		lo.code == 4'h8 |-> lo.carrier == (numeric_oscillator_output ^ lo.invert))
		else $error("numeric oscillator select wrong");
	// capture unit one on code 4
	capture_select_a: assert property ( // R7
		lo.code == 4'h4 |-> lo.carrier == (capture_unit_one_output ^ lo.invert))
		else $error("capture unit select wrong");

	// main scenarios
	synced_fall_c: cover property (lo.sync && lo.active && $fell(lo.carrier));
	synced_wait_c: cover property (lo.sync && lo.want && !lo.active);
	output_toggle_c: cover property (control_ff[dsm_pkg::EN_BIT] ##1 $rose(modulated_out));
	inverted_idle_c: cover property (!control_ff[dsm_pkg::EN_BIT] && control_ff[dsm_pkg::OPOL_BIT]);
endmodule : data_modulator

// ===== src/dsm_pkg.sv
// Overview of operation
// R1: low carrier invert bit 6 flips the selected low carrier.
// R2: low carrier sync bit 5 waits for low carrier falling edge before switching.
// R3: low select codes f,e,d,c pick logic cells four, three, two, one.
// R4: low select code b picks fast oscillator, code a the system clock.
// R5: low select code 9 is reserved and connects nothing.
// R6: code 8 picks numeric oscillator, codes 7 and 6 pulse width six and five.
// R7: codes 5 and 4 pick capture units two and one, PWM mode only.
// R8: code 3 reference clock, codes 2 and 1 pin-selected carrier inputs.
// R9: code 0 ties the low carrier to ground before inversion.
// R10: low carrier bits 7 and 4 ignore writes and read zero.
// R11: carrier fields set at power-on, kept across other resets.
// R12: output follows high carrier while modulation high, low carrier otherwise.
// R13: enable bit mixes signals; cleared, module gives no modulated output.
// R14: an unsynced carrier switches at once; a synced one switches only on its own fall.
// R15: modulation source code 0 uses the software modulation bit.
// R16: output polarity bit inverts the output, idling high.
package dsm_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int PIN_W = 5;
	// register indices
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_SOURCE = 3'h1;
	localparam logic [2:0] OFS_HIGH = 3'h2;
	localparam logic [2:0] OFS_LOW = 3'h3;
	localparam logic [2:0] OFS_CIN1_SEL = 3'h4;
	localparam logic [2:0] OFS_CIN2_SEL = 3'h5;
	localparam logic [2:0] OFS_MIN_SEL = 3'h6;
	// field positions
	localparam int EN_BIT = 7;
	localparam int OPOL_BIT = 4;
	localparam int OUT_BIT = 3;
	localparam int SWBIT_BIT = 0;
	localparam int INV_BIT = 6;
	localparam int SYNC_BIT = 5;
	// writable masks and reset values
	localparam logic [7:0] CONTROL_MASK = 8'h91;
	localparam logic [7:0] SOURCE_MASK = 8'h0f;
	localparam logic [7:0] CARRIER_MASK = 8'h6f;
	localparam logic [7:0] PINSEL_MASK = 8'h1f;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	// carrier and modulation source select codes
	localparam logic [3:0] SEL_VSS = 4'h0;
	localparam logic [3:0] SEL_CIN1 = 4'h1;
	localparam logic [3:0] SEL_RSVD = 4'h9;
	localparam logic [3:0] SEL_CELL4 = 4'hf;
	localparam logic [3:0] MOD_SW = 4'h0;

	// select field of a carrier or source register
	function automatic logic [3:0] sel_of(input logic [7:0] r);
		return r[3:0];
	endfunction : sel_of
endpackage : dsm_pkg

// ===== verification/carrier_source_model.sv
`timescale 1ns/1ps
module carrier_source_model (
	// clock and pacing
	input wire logic mclk,
	input wire logic slow,
	// peripheral levels, indexed by carrier code
	output logic [15:0] src,
	// pins and modulation-only sources
	output logic [31:0] pins,
	output logic [4:0] mods
);
	logic [1:0] pace_ff;

	// idle peripherals start low
	initial begin
		pace_ff = 2'h0;
		src = 16'h0000;
		pins = 32'h00000000;
		mods = 5'h00;
	end

	// new levels every cycle, or every fourth cycle when slow
	always @(posedge mclk) begin
		pace_ff <= pace_ff + 2'h1;
		if (!slow || pace_ff == 2'h0) begin
			src <= 16'($urandom);
			pins <= $urandom;
			mods <= 5'($urandom);
		end
	end
endmodule : carrier_source_model

// ===== verification/data_modulator_low_carrier_tb.sv
`timescale 1ns/1ps
module data_modulator_low_carrier_tb;
	logic mclk;
	logic reset_n;
	logic other_reset;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic modulated_out;
	logic slow;
	logic [15:0] src;
	logic [31:0] pins;
	logic [4:0] mods;
	int err_total;
	int cmp_count;
	logic [7:0] regs [8];
	logic hp, lp, ah, al, out_e, rd_seen;
	logic [7:0] rq [$];
	logic oq [$];

	// free-running system clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	carrier_source_model u_carrier_source_model (.mclk(mclk), .slow(slow), .src(src),
		.pins(pins), .mods(mods));

	data_modulator u_data_modulator (.mclk(mclk), .reset_n(reset_n), .other_reset(other_reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.logic_cell_one_output(src[12]), .logic_cell_two_output(src[13]),
		.logic_cell_three_output(src[14]), .logic_cell_four_output(src[15]),
		.fast_internal_oscillator(src[11]), .system_osc_clock(src[10]),
		.numeric_oscillator_output(src[8]), .pulse_width_five_output(src[6]),
		.pulse_width_six_output(src[7]), .capture_unit_one_output(src[4]),
		.capture_unit_two_output(src[5]), .reference_clock_signal(src[3]),
		.comparator_out(mods[1:0]), .serial_data_out(mods[3:2]), .serial_tx_out(mods[4]),
		.pin_in(pins), .modulated_out(modulated_out));

	// writable bits of each register
	function automatic logic [7:0] mask_of(input logic [2:0] a);
		case (a)
			dsm_pkg::OFS_CONTROL: return dsm_pkg::CONTROL_MASK;
			dsm_pkg::OFS_SOURCE: return dsm_pkg::SOURCE_MASK;
			dsm_pkg::OFS_HIGH, dsm_pkg::OFS_LOW: return dsm_pkg::CARRIER_MASK;
			3'h7: return 8'h00;
			default: return dsm_pkg::PINSEL_MASK;
		endcase
	endfunction : mask_of

	// carrier level before inversion; reserved and ground read low
	function automatic logic src_lvl(input logic [3:0] c);
		case (c)
			4'h0, 4'h9: return 1'b0;
			4'h1: return pins[regs[4][4:0]];
			4'h2: return pins[regs[5][4:0]];
			default: return src[c];
		endcase
	endfunction : src_lvl

	// modulation level for each source code
	function automatic logic mod_lvl(input logic [3:0] c);
		case (c)
			4'h0: return regs[0][dsm_pkg::SWBIT_BIT];
			4'h1: return pins[regs[6][4:0]];
			4'h2, 4'h3, 4'h4, 4'h5: return src[c + 4'h2];
			4'h6, 4'h7, 4'h8, 4'h9, 4'ha: return mods[3'(c - 4'h6)];
			4'hb: return src[8];
			default: return src[c];
		endcase
	endfunction : mod_lvl

	// reference model of registers, carrier gating and output
	always @(posedge mclk or negedge reset_n) begin : ref_model
		logic hc, lc, m, ah_n, al_n;
		if (!reset_n) begin
			foreach (regs[i]) regs[i] = 8'h00;
			{hp, lp, ah, al, out_e, rd_seen} = 6'h00;
		end else begin
			rd_seen = rd;
			if (rd) rq.push_back(regs[addr] | (addr == 3'h0 ? {4'h0, out_e, 3'h0} : 8'h00));
			m = mod_lvl(regs[1][3:0]);
			hc = src_lvl(regs[2][3:0]) ^ regs[2][dsm_pkg::INV_BIT];
			lc = src_lvl(regs[3][3:0]) ^ regs[3][dsm_pkg::INV_BIT];
			ah_n = (regs[2][dsm_pkg::SYNC_BIT] && !(hp && !hc)) ? ah : m;
			al_n = (regs[3][dsm_pkg::SYNC_BIT] && !(lp && !lc)) ? al : !m;
			out_e = regs[0][dsm_pkg::OPOL_BIT] ^
				(regs[0][dsm_pkg::EN_BIT] & ((ah_n & hc) | (al_n & lc)));
			oq.push_back(out_e);
			{hp, lp, ah, al} = {hc, lc, ah_n, al_n};
			if (other_reset) regs[0] = 8'h00;
			else if (wr) regs[addr] = wdata & mask_of(addr);
		end
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask : chk

	// watcher takes the oldest note whenever a result is due
	always @(negedge mclk) begin
		if (!reset_n) begin
			rq.delete();
			oq.delete();
			chk("reset_out", 8'h00, {7'h00, modulated_out});
			chk("reset_rdata", 8'h00, rdata);
		end else begin
			if (oq.size() > 0) chk("out", {7'h00, oq.pop_front()}, {7'h00, modulated_out});
			if (rd_seen) chk("rdata", rq.pop_front(), rdata);
			else chk("idle_rdata", 8'h00, rdata);
		end
	end

	task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d,
		input logic o);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		other_reset <= o;
		@(posedge mclk);
	endtask : cyc

	task automatic test_done();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		test_done();
	end

	// main sequence
	initial begin : stim
		logic [31:0] v;
		err_total = 0;
		cmp_count = 0;
		{reset_n, other_reset, wr, rd, slow} = 5'h00;
		addr = 3'h0;
		wdata = 8'h00;
		v = $urandom(16);
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		for (int a = 0; a < 8; a++) cyc(1'b0, 1'b1, 3'(a), 8'h00, 1'b0);
		for (int a = 0; a < 8; a++) begin
			cyc(1'b1, 1'b0, 3'(a), 8'hff, 1'b0);
			cyc(1'b0, 1'b1, 3'(a), 8'h00, 1'b0);
		end
		for (int i = 0; i < 96; i++) begin
			slow <= i[0];
			for (int a = 1; a < 7; a++) cyc(1'b1, 1'b0, 3'(a), 8'($urandom), 1'b0);
			v = $urandom;
			cyc(1'b1, 1'b0, dsm_pkg::OFS_LOW, {v[7:4], 4'(i)}, 1'b0);
			cyc(1'b1, 1'b0, dsm_pkg::OFS_CONTROL, {i % 5 != 0, v[14:8]}, 1'b0);
			if (i == 48) begin
				reset_n <= 1'b0;
				cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
				reset_n <= 1'b1;
			end
			repeat (24) begin
				v = $urandom;
				cyc(v[0], !v[0] && v[1], v[0] ? dsm_pkg::OFS_CONTROL : v[10:8],
					{1'b1, v[22:16]}, v[7:3] == 5'h00);
			end
		end
		cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
		cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
		test_done();
	end
endmodule : data_modulator_low_carrier_tb
